// [rtl/csc_config_store_control.sv]
// Sequencer and registers for nonvolatile configuration store control
`timescale 1ns/100ps
module csc_config_store_control
  import csc_pkg::*;
#(
  parameter int GAP_CYCLES = CSC_GAP_CYCLES
) (
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  // Store select pin, asynchronous
  input  wire logic        store_sel_n_i,
  // Register port
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [11:0] reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  output logic      [7:0]  reg_rdata_o,
  // Store engine handshake
  output logic             store_save_o,
  output logic             store_load_o,
  output logic             store_wr_en_o,
  input  wire logic        store_done_i,
  input  wire logic        store_err_i,
  // Device reset request
  output logic             soft_reset_o
);
  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // The gap counter is 16 bits wide and must count at least one cycle
  if (GAP_CYCLES < 1 || GAP_CYCLES > 65535) begin : gen_gap_chk
    $error("GAP_CYCLES out of range");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        sel_m;
    logic        sel_s;
    logic        unlock;
    logic        reload;
    logic        save;
    logic        busy;
    logic        err;
    logic [15:0] gap;
    logic        pend_save;
    logic        pend_load;
    csc_state_t  st;
    logic [7:0]  rdata;
    logic        save_p;
    logic        load_p;
    logic        rst_p;
    logic        was_load;
  } csc_regs_t;

  // Field roles:
  //   sel_m, sel_s : two-stage synchroniser for the store select pin
  //   unlock       : store write permission, mirrored on store_wr_en_o
  //   reload       : self-clearing reload request bit
  //   save         : self-clearing save trigger bit
  //   busy, err    : read-only transfer status flags
  //   gap          : cycles left before the next transfer may start
  //   pend_save    : save request waiting for the sequencer
  //   pend_load    : reload request waiting for the sequencer
  //   was_load     : the running transfer is a load, not a save
  //   save_p,
  //   load_p,
  //   rst_p        : one-cycle pulses towards the store engine and device

  csc_regs_t cur_ff;
  csc_regs_t nxt_cur;

  // Widen a flag bit to a byte, flag in bit 0
  function automatic logic [7:0] csc_flag(input logic b);
    csc_flag = {7'h00, b};
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Register writes are applied first and the sequencer second, so a
  // request that lands in the same cycle as a completion is not lost:
  // the completion only clears a bit when no new request came with it.
  // The pin is only ever read through the second synchroniser stage.
  // Only one transfer runs at a time; a request that arrives while the
  // engine is busy, or inside the post-transfer gap, waits as pending.
  always_comb begin
    nxt_cur        = cur_ff;
    nxt_cur.sel_m  = store_sel_n_i;
    nxt_cur.sel_s  = cur_ff.sel_m;
    nxt_cur.save_p = 1'b0;
    nxt_cur.load_p = 1'b0;
    nxt_cur.rst_p  = 1'b0;
    if (cur_ff.gap != 16'h0000) begin
      nxt_cur.gap = cur_ff.gap - 16'h0001;
    end
    // Register writes
    if (reg_wr_i) begin
      case (reg_addr_i)
        CSC_ADDR_CTRL: begin
          nxt_cur.unlock = reg_wdata_i[CSC_BIT_UNLOCK];
          if (reg_wdata_i[CSC_BIT_RELOAD] && !cur_ff.sel_s) begin
            nxt_cur.reload    = 1'b1;
            nxt_cur.pend_load = 1'b1;
          end
        end
        CSC_ADDR_SAVE: begin
          if (reg_wdata_i[CSC_BIT_SAVE]) begin
            nxt_cur.save      = 1'b1;
            nxt_cur.pend_save = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
    // Transfer sequencer
    case (cur_ff.st)
      CSC_IDLE: begin
        if (cur_ff.pend_save) begin
          nxt_cur.pend_save = 1'b0;
          if (!cur_ff.unlock) begin
            nxt_cur.save = 1'b0;
          end else if (cur_ff.gap == 16'h0000) begin
            nxt_cur.save_p   = 1'b1;
            nxt_cur.busy     = 1'b1;
            nxt_cur.err      = 1'b0;
            nxt_cur.was_load = 1'b0;
            nxt_cur.st       = CSC_SAVE;
          end else begin
            nxt_cur.pend_save = 1'b1;
          end
        end else if (cur_ff.pend_load && cur_ff.gap == 16'h0000) begin
          nxt_cur.pend_load = 1'b0;
          nxt_cur.load_p    = 1'b1;
          nxt_cur.busy      = 1'b1;
          nxt_cur.err       = 1'b0;
          nxt_cur.was_load  = 1'b1;
          nxt_cur.st        = CSC_LOAD;
        end
      end
      CSC_SAVE, CSC_LOAD: begin
        if (store_done_i) begin
          nxt_cur.err = store_err_i;
          nxt_cur.st  = CSC_DONE;
        end
      end
      CSC_DONE: begin
        // A save finished: clear its bit unless a new save was written
        if (!cur_ff.was_load && cur_ff.save && !nxt_cur.pend_save) begin
          nxt_cur.save = 1'b0;
        end
        // A reload finished: reset the device, keep a fresh request
        if (cur_ff.was_load && cur_ff.reload) begin
          nxt_cur.rst_p = 1'b1;
          if (!nxt_cur.pend_load) begin
            nxt_cur.reload = 1'b0;
          end
        end
        nxt_cur.busy = 1'b0;
        nxt_cur.gap  = 16'(GAP_CYCLES);
        nxt_cur.st   = CSC_IDLE;
      end
      default: begin
        nxt_cur.st = CSC_IDLE;
      end
    endcase
    // Read data
    nxt_cur.rdata = 8'h00;
    if (reg_rd_i) begin
      case (reg_addr_i)
        CSC_ADDR_BUSY:  nxt_cur.rdata = csc_flag(cur_ff.busy);
        CSC_ADDR_ERROR: nxt_cur.rdata = csc_flag(cur_ff.err);
        CSC_ADDR_CTRL:  nxt_cur.rdata = {6'h00, cur_ff.reload, cur_ff.unlock};
        CSC_ADDR_SAVE:  nxt_cur.rdata = csc_flag(cur_ff.save);
        default:        nxt_cur.rdata = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Reset puts every field to zero and the sequencer to idle; the
  // unlock bit therefore comes up locked and the store is protected.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      cur_ff    <= '0;
      cur_ff.st <= CSC_IDLE;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Outputs straight from flops; pulses last exactly one cycle
  assign reg_rdata_o   = cur_ff.rdata;
  assign store_save_o  = cur_ff.save_p;
  assign store_load_o  = cur_ff.load_p;
  assign store_wr_en_o = cur_ff.unlock;
  assign soft_reset_o  = cur_ff.rst_p;
endmodule

// [rtl/csc_pkg.sv]
// Constants and types for the configuration store control block
// Functional notes
// - Select pin low: reload bit reloads stored settings
// - Reload bit clears itself after the reset
// - Unlock bit zero refuses every store write
// - Unlock bit one allows store writes
// - Writing one to bit 0 starts save
// - Save bit stays one during copy, then clears
// - Busy flag reads one during any transfer
// - Error flag reads one on bad transfer data
package csc_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [11:0] CSC_ADDR_BUSY   = 12'hb00;
  localparam logic [11:0] CSC_ADDR_ERROR  = 12'hb01;
  localparam logic [11:0] CSC_ADDR_CTRL   = 12'hb02;
  localparam logic [11:0] CSC_ADDR_SAVE   = 12'hb03;
  localparam int          CSC_BIT_UNLOCK  = 0;
  localparam int          CSC_BIT_RELOAD  = 1;
  localparam int          CSC_BIT_SAVE    = 0;
  localparam int          CSC_BIT_FLAG    = 0;
  localparam logic [7:0]  CSC_CTRL_RESET  = 8'h00;
  localparam logic [7:0]  CSC_SAVE_RESET  = 8'h00;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CSC_CLK_MHZ     = 200;
  localparam int CSC_GAP_US      = 10;
  localparam int CSC_GAP_CYCLES  = CSC_GAP_US * CSC_CLK_MHZ;
  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    CSC_IDLE = 4'b0001,
    CSC_SAVE = 4'b0010,
    CSC_LOAD = 4'b0100,
    CSC_DONE = 4'b1000
  } csc_state_t;
endpackage

// [sim/csc_checker.sv]
// Port assertions for the configuration store control block
`timescale 1ns/100ps
module csc_checker
  import csc_pkg::*;
(
  input wire logic        clk_sys_i, rst_i, store_sel_n_i, reg_wr_i, reg_rd_i,
  input wire logic [11:0] reg_addr_i,
  input wire logic [7:0]  reg_wdata_i, reg_rdata_o,
  input wire logic        store_save_o, store_load_o, store_wr_en_o,
  input wire logic        store_done_i, store_err_i, soft_reset_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  locked_no_save_a: assert property (store_save_o |-> store_wr_en_o)
    else $error("save pulse while locked");
  unlock_follows_a: assert property (reg_wr_i && reg_addr_i == CSC_ADDR_CTRL
    |=> store_wr_en_o == $past(reg_wdata_i[CSC_BIT_UNLOCK])) else $error("unlock not taken");
  save_pulse_a: assert property (store_save_o |=> !store_save_o)
    else $error("save pulse too long");
  save_held_a: assert property (reg_rd_i && reg_addr_i == CSC_ADDR_SAVE
    && $past(store_save_o) |=> reg_rdata_o == 8'h01) else $error("save bit not held");
  busy_flag_a: assert property (reg_rd_i && reg_addr_i == CSC_ADDR_BUSY
    && $past(store_save_o || store_load_o) |=> reg_rdata_o == 8'h01) else $error("busy low");
  load_pin_low_a: assert property (store_load_o |-> !$past(store_sel_n_i, 3))
    else $error("reload with pin high");
  soft_after_done_a: assert property (soft_reset_o |-> $past(store_done_i, 2))
    else $error("soft reset without load");
  soft_once_a: assert property (soft_reset_o |=> !soft_reset_o)
    else $error("soft reset not cleared");
endmodule
bind csc_config_store_control csc_checker csc_checker_inst (.clk_sys_i, .rst_i,
  .store_sel_n_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o,
  .store_save_o, .store_load_o, .store_wr_en_o, .store_done_i, .store_err_i, .soft_reset_o);

// [sim/csc_store_model.sv]
// Behavioural store engine answering save and load requests
`timescale 1ns/100ps
module csc_store_model (
  input  wire logic       clk_sys_i, save_i, load_i, bad_i,
  input  wire logic [3:0] dly_i,
  output logic            done_o, err_o
);
  logic [3:0] cnt_ff = 4'h0;
  // Latency count, done when it reaches one
  always_ff @(posedge clk_sys_i)
    cnt_ff <= (save_i | load_i) ? dly_i : cnt_ff - {3'h0, |cnt_ff};
  assign done_o = cnt_ff == 4'h1;
  assign err_o  = done_o ? bad_i : cnt_ff[0]; // Junk outside done
endmodule

// [sim/tb_csc_config_store_control.sv]
// Self-checking bench for the configuration store control block
`timescale 1ns/100ps
module tb_csc_config_store_control;
  import csc_pkg::*;
  logic        clk_sys_i = 0, rst_i = 1, sel_n = 0, wr = 0, rd = 0, bad = 0;
  logic        sv, ld, wen, dn, er, sr;
  logic [11:0] addr = 12'h000, ra;
  logic [7:0]  wd = 8'h00, rdat;
  logic [3:0]  dly = 4'h3;
  int          num_errors = 0, checked = 0, dn_cnt = 0, dn_exp = 0;
  csc_config_store_control #(.GAP_CYCLES(20)) csc_config_store_control_inst (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .store_sel_n_i(sel_n), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wd), .reg_rdata_o(rdat),
    .store_save_o(sv), .store_load_o(ld), .store_wr_en_o(wen), .store_done_i(dn),
    .store_err_i(er), .soft_reset_o(sr));
  csc_store_model csc_store_model_inst (.clk_sys_i(clk_sys_i), .save_i(sv), .load_i(ld),
    .bad_i(bad), .dly_i(dly), .done_o(dn), .err_o(er));
  initial forever #2.5 clk_sys_i = ~clk_sys_i;
  // Count completions so a short done pulse is never missed
  always @(posedge clk_sys_i) if (dn) dn_cnt <= dn_cnt + 1;
  task chk(input logic [7:0] s, input logic [7:0] e);
    checked++;
    if (s !== e) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task final_report;
    if (num_errors == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task wr_reg(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    wr <= 1;
    addr <= a;
    wd <= d;
    @(posedge clk_sys_i);
    wr <= 0;
  endtask
  task rd_reg(input logic [11:0] a, input logic [7:0] e);
    @(posedge clk_sys_i);
    rd <= 1;
    addr <= a;
    @(posedge clk_sys_i);
    rd <= 0;
    #1 chk(rdat, e);
  endtask
  // Bounded wait on 0 save, 1 load, 2 soft reset, 3 done
  task wait_on(input int w);
    logic [3:0] v;
    for (int i = 0; i < 100; i++) begin
      @(posedge clk_sys_i);
      #1 v = {dn_cnt > dn_exp, sr, ld, sv};
      if (v[w]) return;
    end
    num_errors++;
    final_report();
  endtask
  initial begin
    void'($urandom(32'h10249dd4));
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 0;
    rd_reg(CSC_ADDR_CTRL, CSC_CTRL_RESET);
    wr_reg(CSC_ADDR_SAVE, 8'h01);
    repeat (4) @(posedge clk_sys_i);
    rd_reg(CSC_ADDR_SAVE, CSC_SAVE_RESET);
    for (int k = 0; k < 6; k++) begin
      dly <= 4'($urandom_range(3, 8));
      bad <= k[0];
      ra = 12'h100 + 12'($urandom_range(0, 255));
      wr_reg(ra, 8'($urandom));
      rd_reg(ra, 8'h00);
      repeat (25) @(posedge clk_sys_i);
      wr_reg(CSC_ADDR_CTRL, 8'h01);
      rd_reg(CSC_ADDR_CTRL, 8'h01);
      wr_reg(CSC_ADDR_SAVE, 8'h01);
      wait_on(0);
      dn_exp = dn_cnt;
      rd_reg(CSC_ADDR_SAVE, 8'h01);
      rd_reg(CSC_ADDR_BUSY, 8'h01);
      wait_on(3);
      repeat (3) @(posedge clk_sys_i);
      rd_reg(CSC_ADDR_SAVE, 8'h00);
      rd_reg(CSC_ADDR_BUSY, 8'h00);
      rd_reg(CSC_ADDR_ERROR, {7'h00, k[0]});
      // Reload from the store, refused while the pin is high
      sel_n <= k[1];
      repeat (25) @(posedge clk_sys_i);
      wr_reg(CSC_ADDR_CTRL, 8'h02);
      if (!k[1]) wait_on(2);
      rd_reg(CSC_ADDR_CTRL, 8'h00);
    end
    final_report();
  end
endmodule
